// ### logic/agm_ahb_front.sv
// ahb-lite slave front end: address capture, write strobe, read wait state
`timescale 1ns/1ps
`default_nettype none
`include "agm_params.svh"

module agm_ahb_front (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	output logic             wr_en,
	output logic      [7:0]  acc_addr,
	output logic             acc_mapped,
	output logic      [15:0] wr_data,
	input  wire logic [15:0] rd_data
);

	agm_pkg::agm_phase_t phase_reg;
	logic [31:0]         addr_reg;
	logic                word_reg;
	logic                start;

	assign start = hsel && hready && htrans[1];

	// data-phase tracking; reads take one wait state so that a write just before is seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_reg <= agm_pkg::AGM_PH_IDLE;
		end else if (start) begin
			phase_reg <= hwrite ? agm_pkg::AGM_PH_WDATA : agm_pkg::AGM_PH_RWAIT;
		end else if (phase_reg == agm_pkg::AGM_PH_RWAIT) begin
			phase_reg <= agm_pkg::AGM_PH_RDATA;
		end else if (hready) begin
			phase_reg <= agm_pkg::AGM_PH_IDLE;
		end
	end

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_reg <= 32'h0000_0000;
			word_reg <= 1'b0;
		end else if (start) begin
			addr_reg <= haddr;
			word_reg <= (hsize == `AGM_HSIZE_WORD);
		end
	end

	// read data taken at the end of the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (phase_reg == agm_pkg::AGM_PH_RWAIT) begin
			hrdata <= {16'h0000, rd_data};
		end
	end

	// unmapped addresses: reads return zero, writes are dropped, answer stays okay
	assign acc_addr   = addr_reg[7:0];
	assign acc_mapped = (addr_reg[31:8] == 24'h00_0000) && (addr_reg[1:0] == 2'b00);
	assign wr_en      = (phase_reg == agm_pkg::AGM_PH_WDATA) && word_reg;
	assign wr_data    = hwdata[15:0];
	assign hreadyout  = (phase_reg != agm_pkg::AGM_PH_RWAIT);
	assign hresp      = 1'b0;

endmodule : agm_ahb_front
`default_nettype wire

// ### logic/agm_code_to_stage.sv
// translation of a uniform-step gain code into a stage-control word
`timescale 1ns/1ps
`default_nettype none
`include "agm_params.svh"

module agm_code_to_stage (
	input  wire logic [15:0] code,
	output logic      [15:0] stage
);

	// code/8 equals 2*fine/16 with fine = code, so the doubling stage is always usable
	// for codes up to 127; that mapping is the lower-noise one. larger codes saturate.
	always_comb begin
		if (code <= `AGM_CODE_DIRECT_MAX) begin
			stage = {8'h00, 1'b1, code[`AGM_STAGE_FINE_MSB:0]};
		end else begin
			stage = `AGM_STAGE_MAX;
		end
	end

endmodule : agm_code_to_stage
`default_nettype wire

// ### logic/agm_gain_regs.sv
// analog gain register bank: uniform-step codes, stage-control words, stage outputs
//
// Contract
// - capability register is read-only and always reads one.
// - a global gain write stores the value into all four colour registers.
// - a global gain read returns the green-on-red-row colour register.
// - gain mode register is read/write and has no effect on gain.
// - uniform-step gain equals the code divided by eight; the bank saturates codes above 127 to AGM_STAGE_MAX.
// - stage gain is (bit7 plus one) times bits 6..0 over sixteen.
// - a written code is converted and readable from the matching stage register.
// - when several stage words fit a code, the doubling one is chosen.
// - after a direct stage write, the code readback is undefined.
`timescale 1ns/1ps
`default_nettype none
`include "agm_params.svh"

module agm_gain_regs (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	output logic             stage_double_green_red_row,
	output logic      [6:0]  stage_fine_green_red_row,
	output logic             stage_double_red,
	output logic      [6:0]  stage_fine_red,
	output logic             stage_double_blue,
	output logic      [6:0]  stage_fine_blue,
	output logic             stage_double_green_blue_row,
	output logic      [6:0]  stage_fine_green_blue_row
);

	localparam int NUM_COLOURS = 4;

	// ==========================================================
	// bus front end
	// ==========================================================

	logic        wr_en;
	logic [7:0]  acc_addr;
	logic        acc_mapped;
	logic [15:0] wr_data;
	logic [15:0] rd_data;
	logic [15:0] conv_stage;

	// zero wait writes, one wait state reads
	agm_ahb_front u_front (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.hsel       (hsel),
		.haddr      (haddr),
		.htrans     (htrans),
		.hwrite     (hwrite),
		.hsize      (hsize),
		.hwdata     (hwdata),
		.hready     (hready),
		.hreadyout  (hreadyout),
		.hresp      (hresp),
		.hrdata     (hrdata),
		.wr_en      (wr_en),
		.acc_addr   (acc_addr),
		.acc_mapped (acc_mapped),
		.wr_data    (wr_data),
		.rd_data    (rd_data)
	);

	// one converter serves every code write; only one write lands per cycle
	agm_code_to_stage u_conv (
		.code  (wr_data),
		.stage (conv_stage)
	);

	// ==========================================================
	// write decode
	// ==========================================================

	logic                   wr_gain_mode;
	logic                   wr_code_global;
	logic                   wr_stage_all;
	logic [NUM_COLOURS-1:0] wr_code_col;
	logic [NUM_COLOURS-1:0] wr_stage_col;

	// single-register strobes from the captured address
	always_comb begin
		wr_gain_mode   = wr_en && acc_mapped && (acc_addr == `AGM_OFF_GAIN_MODE);
		wr_code_global = wr_en && acc_mapped && (acc_addr == `AGM_OFF_CODE_GLOBAL);
		wr_stage_all   = wr_en && acc_mapped && (acc_addr == `AGM_OFF_STAGE_ALL);
		wr_code_col[agm_pkg::AGM_COL_GR]    = wr_en && acc_mapped && (acc_addr == `AGM_OFF_CODE_GR);
		wr_code_col[agm_pkg::AGM_COL_RED]   = wr_en && acc_mapped && (acc_addr == `AGM_OFF_CODE_RED);
		wr_code_col[agm_pkg::AGM_COL_BLUE]  = wr_en && acc_mapped && (acc_addr == `AGM_OFF_CODE_BLUE);
		wr_code_col[agm_pkg::AGM_COL_GB]    = wr_en && acc_mapped && (acc_addr == `AGM_OFF_CODE_GB);
		wr_stage_col[agm_pkg::AGM_COL_GR]   = wr_en && acc_mapped && (acc_addr == `AGM_OFF_STAGE_GR);
		wr_stage_col[agm_pkg::AGM_COL_RED]  = wr_en && acc_mapped && (acc_addr == `AGM_OFF_STAGE_RED);
		wr_stage_col[agm_pkg::AGM_COL_BLUE] = wr_en && acc_mapped && (acc_addr == `AGM_OFF_STAGE_BLUE);
		wr_stage_col[agm_pkg::AGM_COL_GB]   = wr_en && acc_mapped && (acc_addr == `AGM_OFF_STAGE_GB);
	end

	// ==========================================================
	// registers
	// ==========================================================

	logic [15:0] gain_mode_reg;
	logic [15:0] code_reg  [NUM_COLOURS];
	logic [15:0] stage_reg [NUM_COLOURS];

	// gain mode is plain storage; nothing in the gain path looks at it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gain_mode_reg <= `AGM_GAIN_MODE_RESET;
		end else if (wr_gain_mode) begin
			gain_mode_reg <= wr_data;
		end
	end

	// per colour storage; global writes alias onto every colour
	genvar c;
	generate
		for (c = 0; c < NUM_COLOURS; c++) begin : g_col
			// uniform-step code, kept as written; gain = code/8 after translation for codes up to 127
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					code_reg[c] <= `AGM_CODE_RESET;
				end else if (wr_code_global || wr_code_col[c]) begin
					code_reg[c] <= wr_data;
				end
			end

			// stage word: direct writes store as is, code writes store the translation.
			// a direct write leaves the code register stale, which software must not trust.
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					stage_reg[c] <= `AGM_STAGE_RESET;
				end else if (wr_stage_all || wr_stage_col[c]) begin
					stage_reg[c] <= wr_data;
				end else if (wr_code_global || wr_code_col[c]) begin
					stage_reg[c] <= conv_stage;
				end
			end
		end
	endgenerate

	// ==========================================================
	// read mux
	// ==========================================================

	// global registers read back through the green-on-red-row colour
	always_comb begin
		rd_data = 16'h0000;
		if (acc_mapped) begin
			unique case (acc_addr)
				`AGM_OFF_CAPABILITY:  rd_data = `AGM_CAPABILITY_VALUE;
				`AGM_OFF_GAIN_MODE:   rd_data = gain_mode_reg;
				`AGM_OFF_CODE_GLOBAL: rd_data = code_reg[agm_pkg::AGM_COL_GR];
				`AGM_OFF_CODE_GR:     rd_data = code_reg[agm_pkg::AGM_COL_GR];
				`AGM_OFF_CODE_RED:    rd_data = code_reg[agm_pkg::AGM_COL_RED];
				`AGM_OFF_CODE_BLUE:   rd_data = code_reg[agm_pkg::AGM_COL_BLUE];
				`AGM_OFF_CODE_GB:     rd_data = code_reg[agm_pkg::AGM_COL_GB];
				`AGM_OFF_STAGE_ALL:   rd_data = stage_reg[agm_pkg::AGM_COL_GR];
				`AGM_OFF_STAGE_GR:    rd_data = stage_reg[agm_pkg::AGM_COL_GR];
				`AGM_OFF_STAGE_RED:   rd_data = stage_reg[agm_pkg::AGM_COL_RED];
				`AGM_OFF_STAGE_BLUE:  rd_data = stage_reg[agm_pkg::AGM_COL_BLUE];
				`AGM_OFF_STAGE_GB:    rd_data = stage_reg[agm_pkg::AGM_COL_GB];
				default:              rd_data = 16'h0000; // unmapped reads as zero
			endcase
		end
	end

	// ==========================================================
	// analog stage outputs
	// ==========================================================

	// straight from the stage flops; bits above 7 do not reach the analog chain
	assign stage_double_green_red_row  = stage_reg[agm_pkg::AGM_COL_GR][`AGM_STAGE_DOUBLE_BIT];
	assign stage_fine_green_red_row    = stage_reg[agm_pkg::AGM_COL_GR][`AGM_STAGE_FINE_MSB:0];
	assign stage_double_red            = stage_reg[agm_pkg::AGM_COL_RED][`AGM_STAGE_DOUBLE_BIT];
	assign stage_fine_red              = stage_reg[agm_pkg::AGM_COL_RED][`AGM_STAGE_FINE_MSB:0];
	assign stage_double_blue           = stage_reg[agm_pkg::AGM_COL_BLUE][`AGM_STAGE_DOUBLE_BIT];
	assign stage_fine_blue             = stage_reg[agm_pkg::AGM_COL_BLUE][`AGM_STAGE_FINE_MSB:0];
	assign stage_double_green_blue_row = stage_reg[agm_pkg::AGM_COL_GB][`AGM_STAGE_DOUBLE_BIT];
	assign stage_fine_green_blue_row   = stage_reg[agm_pkg::AGM_COL_GB][`AGM_STAGE_FINE_MSB:0];

endmodule : agm_gain_regs
`default_nettype wire

// ### logic/agm_params.svh
// offsets, reset values and field positions of the analog gain code mapper
`ifndef AGM_PARAMS_SVH
`define AGM_PARAMS_SVH

// byte offsets of the register map (one aligned word each)
`define AGM_OFF_CAPABILITY     8'h00
`define AGM_OFF_GAIN_MODE      8'h04
`define AGM_OFF_CODE_GLOBAL    8'h08
`define AGM_OFF_CODE_GR        8'h0C
`define AGM_OFF_CODE_RED       8'h10
`define AGM_OFF_CODE_BLUE      8'h14
`define AGM_OFF_CODE_GB        8'h18
`define AGM_OFF_STAGE_ALL      8'h1C
`define AGM_OFF_STAGE_GR       8'h20
`define AGM_OFF_STAGE_RED      8'h24
`define AGM_OFF_STAGE_BLUE     8'h28
`define AGM_OFF_STAGE_GB       8'h2C

// values and reset values
`define AGM_CAPABILITY_VALUE   16'h0001
`define AGM_GAIN_MODE_RESET    16'h0000
`define AGM_CODE_RESET         16'h0008
`define AGM_STAGE_RESET        16'h0088
`define AGM_STAGE_MAX          16'h00FF

// uniform-step codes and stage fields
`define AGM_CODE_DIVISOR       8
`define AGM_STAGE_DIVISOR      16
`define AGM_CODE_DIRECT_MAX    16'h007F
`define AGM_STAGE_DOUBLE_BIT   7
`define AGM_STAGE_FINE_MSB     6
`define AGM_HSIZE_WORD         3'h2

`endif

// ### logic/agm_pkg.sv
// types shared by the analog gain code mapper
`default_nettype none
package agm_pkg;

	// ahb slave data-phase tracking
	typedef enum logic [1:0] {
		AGM_PH_IDLE  = 2'b00,
		AGM_PH_WDATA = 2'b01,
		AGM_PH_RWAIT = 2'b10,
		AGM_PH_RDATA = 2'b11
	} agm_phase_t;

	// colour channel index
	typedef enum logic [1:0] {
		AGM_COL_GR   = 2'b00,
		AGM_COL_RED  = 2'b01,
		AGM_COL_BLUE = 2'b10,
		AGM_COL_GB   = 2'b11
	} agm_colour_t;

endpackage : agm_pkg
`default_nettype wire

// ### tb/agm_gain_regs_assertions.sv
// port checker for the analog gain register bank
`timescale 1ns/1ps
`default_nettype none
module agm_gain_regs_assertions (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        stage_double_green_red_row,
	input wire logic [6:0]  stage_fine_green_red_row,
	input wire logic        stage_double_red,
	input wire logic [6:0]  stage_fine_red,
	input wire logic        stage_double_blue,
	input wire logic [6:0]  stage_fine_blue,
	input wire logic        stage_double_green_blue_row,
	input wire logic [6:0]  stage_fine_green_blue_row
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic       tk_rd;
	logic       tk_wr;
	logic [7:0] w_gr;
	logic [7:0] w_rd;
	logic [7:0] w_bl;
	logic [7:0] w_gb;
	// taken transfers and the stage word each colour presents
	assign tk_rd = hsel && hready && htrans[1] && !hwrite;
	assign tk_wr = hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
	assign w_gr = {stage_double_green_red_row, stage_fine_green_red_row};
	assign w_rd = {stage_double_red, stage_fine_red};
	assign w_bl = {stage_double_blue, stage_fine_blue};
	assign w_gb = {stage_double_green_blue_row, stage_fine_green_blue_row};
	// ====================
	// checks
	sequence s_rd_ans;
		!hreadyout ##1 hreadyout;
	endsequence
	a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
	a_read_wait: assert property (tk_rd |=> s_rd_ans) else $error("read wait state wrong");
	a_write_nowait: assert property (tk_wr |=> hreadyout) else $error("write stalled");
	a_cap_value: assert property (tk_rd && haddr == 32'h0 |=> s_rd_ans ##0 hrdata == 32'h1)
		else $error("capability not one");
	a_gr_alias: assert property (tk_rd && haddr == 32'h1C |=> s_rd_ans ##0 hrdata[7:0] == w_gr)
		else $error("global read not green row word");
	a_all_write: assert property (tk_wr && haddr == 32'h1C ##1 1'b1 |=> w_gr == $past(hwdata[7:0])
		&& w_rd == w_gr && w_bl == w_gr && w_gb == w_gr) else $error("global stage write not aliased");
	a_code_map: assert property (tk_wr && haddr == 32'h10 ##1 hwdata[15:0] <= 16'h7F
		|=> w_rd == {1'b1, $past(hwdata[6:0])}) else $error("code mapping wrong");
	a_code_all: assert property (tk_wr && haddr == 32'h08 ##1 hwdata[15:0] <= 16'h7F
		|=> w_gb == {1'b1, $past(hwdata[6:0])} && w_gr == w_gb) else $error("global code not aliased");
	a_stage_hold: assert property (!$past(tk_wr, 2) |-> $stable({w_gr, w_rd, w_bl, w_gb}))
		else $error("stage outputs moved without write");
endmodule : agm_gain_regs_assertions
bind agm_gain_regs agm_gain_regs_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.stage_double_green_red_row(stage_double_green_red_row), .stage_fine_green_red_row(stage_fine_green_red_row),
	.stage_double_red(stage_double_red), .stage_fine_red(stage_fine_red),
	.stage_double_blue(stage_double_blue), .stage_fine_blue(stage_fine_blue),
	.stage_double_green_blue_row(stage_double_green_blue_row),
	.stage_fine_green_blue_row(stage_fine_green_blue_row));
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the analog gain register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {logic [7:0] wa; logic [15:0] wd; logic [7:0] ra; logic [15:0] ex;} agm_row_t;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [3:0]  dbl;
	logic [6:0]  fin [4];
	logic [31:0] r;
	int          num_errors = 0;
	int          check_count = 0;
	// write row, then read row and the value it must return
	localparam agm_row_t rows [14] = '{
		'{8'h10, 16'h0010, 8'h24, 16'h0090}, '{8'h18, 16'h0040, 8'h2C, 16'h00C0},
		'{8'h14, 16'h007F, 8'h28, 16'h00FF}, '{8'h0C, 16'h0001, 8'h20, 16'h0081},
		'{8'h08, 16'h0020, 8'h2C, 16'h00A0}, '{8'h08, 16'h0010, 8'h08, 16'h0010},
		'{8'h1C, 16'h0120, 8'h24, 16'h0120}, '{8'h20, 16'h0085, 8'h1C, 16'h0085},
		'{8'h28, 16'h0190, 8'h28, 16'h0190}, '{8'h04, 16'h0005, 8'h04, 16'h0005},
		'{8'h00, 16'h1234, 8'h00, 16'h0001}, '{8'h30, 16'h1111, 8'h30, 16'h0000},
		'{8'h10, 16'h0100, 8'h24, 16'h00FF}, '{8'h26, 16'h0011, 8'h24, 16'h00FF}};
	always #2 hclk = ~hclk;
	agm_gain_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .stage_double_green_red_row(dbl[0]), .stage_fine_green_red_row(fin[0]),
		.stage_double_red(dbl[1]), .stage_fine_red(fin[1]), .stage_double_blue(dbl[2]),
		.stage_fine_blue(fin[2]), .stage_double_green_blue_row(dbl[3]), .stage_fine_green_blue_row(fin[3]));
	// ====================
	// tasks
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_reg
	task automatic chk_out(input logic [7:0] e);
		for (int c = 0; c < 4; c++) begin
			check_count++;
			if ({dbl[c], fin[c]} !== e) begin
				num_errors++;
				$display("ERROR stage out %0d expected %h seen %h", c, e, {dbl[c], fin[c]});
			end
		end
	endtask : chk_out
	// each phase is held until ready is sampled high at a rising edge; read data is taken at that same edge.
	// select is dropped only once per call, so a following call never reassigns it in the same time step
	task automatic ahb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [2:0] sz);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= sz;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {16'h0, d};
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		r = hrdata;
		if (n >= 40) begin
			num_errors++;
			close_out();
		end
	endtask : ahb
	// ====================
	// sequence
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk_out(8'h88);
		ahb(1'b0, 8'h0C, 16'h0, 3'h2);
		chk_reg("code reset", 32'h8, r);
		$display("test reset done");
		foreach (rows[i]) begin
			ahb(1'b1, rows[i].wa, rows[i].wd, 3'h2);
			ahb(1'b0, rows[i].ra, 16'h0, 3'h2);
			chk_reg("row read", {16'h0, rows[i].ex}, r);
		end
		$display("test rows done");
		ahb(1'b1, 8'h1C, 16'h00C5, 3'h2);
		@(negedge hclk);
		chk_out(8'hC5);
		@(posedge hclk);
		ahb(1'b1, 8'h04, 16'h00AA, 3'h0);
		ahb(1'b0, 8'h04, 16'h0, 3'h2);
		chk_reg("byte write", 32'h5, r);
		$display("test alias and size done");
		hresetn <= 1'b0;
		@(negedge hclk);
		chk_out(8'h88);
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, 8'h04, 16'h0, 3'h2);
		chk_reg("mode reset", 32'h0, r);
		$display("test second reset done");
		close_out();
	end
endmodule : tb_top
`default_nettype wire
